// file: startup_defines.svh
// timing counts and duty and speed constants for the startup sequencer
// assumes a 125 MHz core clock
`ifndef STARTUP_DEFINES_SVH
`define STARTUP_DEFINES_SVH
`define CLK_PERIOD_NS       8
`define CYCLES_PER_MS       (1000000 / `CLK_PERIOD_NS)
`define RAMP_PERIOD_MS      5000
`define RAMP_CYCLES         (`RAMP_PERIOD_MS * `CYCLES_PER_MS)
`define BRAKE_SKIP_MS       200
`define BRAKE_SKIP_CYCLES   (`BRAKE_SKIP_MS * `CYCLES_PER_MS)
`define INIT_CYCLES         1024
`define CHARGE_CYCLES       4096
`define DUTY_STEP_CYCLES    256
`define HOLD_UNIT_CYCLES    4096
`define DUTY_FULL           8'hFF
`define SPEED_START_PCT     25
`endif

// file: startup_pkg.sv
// types shared by the startup sequencer
// constants live in startup_defines.svh
package startup_pkg;
	typedef enum logic [2:0] {
		st_off, st_user_brake, st_all_off, st_charge, st_wm_brake, st_hold, st_drive, st_run
	} phase_e;
	typedef struct packed {
		logic       startup_mode_select;
		logic [3:0] ramp_period_setting;
		logic [5:0] hold_time_setting;
		logic [3:0] hold_current_setting;
		logic [4:0] startup_speed_setting;
		logic [4:0] startup_duty_setting;
		logic [1:0] windmill_current_limit;
		logic [1:0] windmill_stop_threshold;
	} config_s;
	typedef struct packed {
		logic       low_side_on;
		logic [7:0] low_duty;
		logic       dc_hold;
		logic [7:0] hold_level;
		logic       open_loop;
		logic [7:0] speed_pct;
		logic       closed_loop;
	} drive_s;
endpackage : startup_pkg

// file: duty_ramp.sv
// step ramp: a level rises one step per period while enabled, up to a ceiling
// assumes same clock and synchronous reset copy
`timescale 1ns/100ps
module duty_ramp #(
	parameter int W    = 8,
	parameter int STEP = 256
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         clear,
	input  wire logic         enable,
	input  wire logic [W-1:0] ceiling,
	output logic      [W-1:0] level
);
	initial if (W < 1 || STEP < 1 || STEP > 65536) $error("duty_ramp parameters out of range");
	typedef struct packed {
		logic [W-1:0]  lvl;
		logic [15:0]   cnt;
	} ramp_s;
	ramp_s st, next_st;
	always_comb begin
		next_st = st;
		if (clear) begin
			next_st = '0;
		end else if (enable && st.lvl < ceiling) begin
			if (st.cnt == 16'(STEP - 1)) begin
				next_st.cnt = '0;
				next_st.lvl = st.lvl + 1'b1;
			end else begin
				next_st.cnt = st.cnt + 16'h0001;
			end
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) st <= '0;
		else st <= next_st;
	end
	assign level = st.lvl;
endmodule : duty_ramp

// file: motor_startup_sequencer.sv
// startup sequencer: brakes, charges, aligns or ramps, then hands over to run
// assumes current sense and speed-voltage comparisons arrive as pins
//
// Overview of operation
// - one mode bit picks DC alignment or open-loop ramp-up start.
// - before either start, all low sides brake with a step-rising fixed-period duty under current limit.
// - braking peaks at full duty and the brake phase ends when sensed current falls below the selected stop threshold.
// - alignment ramps a DC coil current from zero to the hold current and keeps it for the hold time.
// - after the hold time the motor runs at constant speed under the closed-loop duty.
// - ramp-up raises excitation speed from 25 to 100 percent of startup speed over about 5 s.
// - ramp-up runs open loop and switches to position estimation at full startup speed.
// - after the ramp period the motor runs at constant speed under the closed-loop duty.
// - hold time and hold current are programmable fields; the ramp period, startup speed and startup duty fields go unused.
// - phases run user brake, all off, charge, windmill brake, hold or drive, then run.
// - the user brake is skipped when the speed voltage sits in its brake range under about 200 ms.
// - windmill braking raises low duty until the current reaches the selected limit.
// - the motor counts as stopped when windmill current falls below the selected threshold.
// - user brake lasts until the speed voltage passes the excitation start voltage.
`timescale 1ns/100ps
`include "startup_defines.svh"
module motor_startup_sequencer #(
	parameter int RAMP_CYCLES       = `RAMP_CYCLES,
	parameter int BRAKE_SKIP_CYCLES = `BRAKE_SKIP_CYCLES,
	parameter int CHARGE_CYCLES     = `CHARGE_CYCLES,
	parameter int HOLD_UNIT_CYCLES  = `HOLD_UNIT_CYCLES,
	parameter int STEP_CYCLES       = `DUTY_STEP_CYCLES
) (
	input  wire logic                core_clk,
	input  wire logic                resetn,
	input  wire logic                run_enable,
	input  wire startup_pkg::config_s cfg,
	input  wire logic                vsp_in_brake_range,
	input  wire logic                vsp_above_start,
	input  wire logic [1:0]          current_level,
	output startup_pkg::drive_s      drive,
	output startup_pkg::phase_e      phase,
	output logic                     position_estimate
);
	import startup_pkg::*;
	localparam int CW = 32;
	initial if (RAMP_CYCLES < 4 || BRAKE_SKIP_CYCLES < 1 || CHARGE_CYCLES < 1 || HOLD_UNIT_CYCLES < 1)
		$error("motor_startup_sequencer counts too small");

	logic rst_a, rst_n;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_a <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_a <= 1'b1;
			rst_n <= rst_a;
		end
	end

	// two-flop sync of pin inputs
	logic [3:0] sync1, sync2;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
		end else begin
			sync1 <= {vsp_in_brake_range, vsp_above_start, current_level};
			sync2 <= sync1;
		end
	end
	wire       in_brake = sync2[3];
	wire       above_st = sync2[2];
	wire [1:0] cur      = sync2[1:0];

	typedef struct packed {
		phase_e      ph;
		logic [CW-1:0] cnt;
		logic [CW-1:0] uc_time;
		logic        estimate;
	} seq_s;
	seq_s s, next_s;

	logic [7:0] ramp_level;
	logic       ramp_clear, ramp_en;
	logic [7:0] ramp_ceiling;
	duty_ramp #(.W(8), .STEP(STEP_CYCLES)) u_ramp (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clear    (ramp_clear),
		.enable   (ramp_en),
		.ceiling  (ramp_ceiling),
		.level    (ramp_level)
	);

	wire [7:0] hold_target = {cfg.hold_current_setting, 4'hF};
	wire [CW-1:0] hold_cycles = CW'(cfg.hold_time_setting) * CW'(HOLD_UNIT_CYCLES);
	wire [1:0] limit_code = cfg.windmill_current_limit;
	wire [1:0] stop_code  = cfg.windmill_stop_threshold;
	wire       at_limit   = cur >= limit_code;
	wire       stopped    = cur < stop_code || cur == 2'b00;

	always_comb begin
		next_s = s;
		ramp_clear = 1'b0;
		ramp_en = 1'b0;
		ramp_ceiling = `DUTY_FULL;
		if (!run_enable) begin
			next_s = '0;
			next_s.ph = st_off;
			ramp_clear = 1'b1;
		end else begin
			case (s.ph)
				st_off: begin
					next_s.ph = st_user_brake;
					next_s.uc_time = '0;
					ramp_clear = 1'b1;
				end
				st_user_brake: begin
					ramp_en = ~at_limit;
					if (in_brake && s.uc_time < CW'(BRAKE_SKIP_CYCLES)) next_s.uc_time = s.uc_time + 1'b1;
					if (above_st) begin
						next_s.ph = st_all_off;
						next_s.cnt = '0;
						ramp_clear = 1'b1;
					end
				end
				st_all_off: begin
					ramp_clear = 1'b1;
					next_s.cnt = s.cnt + 1'b1;
					if (s.cnt == CW'(`INIT_CYCLES - 1)) begin
						next_s.ph = st_charge;
						next_s.cnt = '0;
					end
				end
				st_charge: begin
					next_s.cnt = s.cnt + 1'b1;
					if (s.cnt == CW'(CHARGE_CYCLES - 1)) begin
						next_s.ph = st_wm_brake;
						next_s.cnt = '0;
					end
				end
				st_wm_brake: begin
					ramp_en = ~at_limit;
					if (ramp_level == `DUTY_FULL && stopped) begin
						next_s.ph = cfg.startup_mode_select ? st_drive : st_hold;
						next_s.cnt = '0;
						ramp_clear = 1'b1;
					end
				end
				st_hold: begin
					ramp_ceiling = hold_target;
					ramp_en = 1'b1;
					if (ramp_level == hold_target) next_s.cnt = s.cnt + 1'b1;
					if (ramp_level == hold_target && s.cnt >= hold_cycles) next_s.ph = st_run;
				end
				st_drive: begin
					next_s.cnt = s.cnt + 1'b1;
					if (s.cnt == CW'(RAMP_CYCLES - 1)) begin
						next_s.ph = st_run;
						next_s.estimate = 1'b1;
					end
				end
				st_run: next_s.estimate = 1'b1;
				default: next_s.ph = st_off;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) s <= '0;
		else s <= next_s;
	end

	// user brake shown on the pins only after it lasted past the skip time
	wire uc_visible = s.uc_time >= CW'(BRAKE_SKIP_CYCLES);
	wire [7:0] ramp_pct = 8'(64'(`SPEED_START_PCT) + (64'(100 - `SPEED_START_PCT) * 64'(s.cnt)) / 64'(RAMP_CYCLES));
	drive_s next_drive;
	always_comb begin
		next_drive = '0;
		case (s.ph)
			st_user_brake: begin
				next_drive.low_side_on = uc_visible;
				next_drive.low_duty = uc_visible ? ramp_level : 8'h00;
			end
			st_charge: begin
				next_drive.low_side_on = 1'b1;
				next_drive.low_duty = `DUTY_FULL;
			end
			st_wm_brake: begin
				next_drive.low_side_on = 1'b1;
				next_drive.low_duty = ramp_level;
			end
			st_hold: begin
				next_drive.dc_hold = 1'b1;
				next_drive.hold_level = ramp_level;
			end
			st_drive: begin
				next_drive.open_loop = 1'b1;
				next_drive.speed_pct = ramp_pct;
			end
			st_run: begin
				next_drive.closed_loop = 1'b1;
				next_drive.speed_pct = 8'h64;
			end
			default: next_drive = '0;
		endcase
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			drive <= '0;
			phase <= st_off;
			position_estimate <= 1'b0;
		end else begin
			drive <= next_drive;
			phase <= s.ph;
			position_estimate <= s.estimate;
		end
	end

	sequence seq_brake_done;
		s.ph == st_wm_brake && ramp_level == `DUTY_FULL && stopped && run_enable;
	endsequence
	order_check_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		s.ph == st_all_off && next_s.ph != st_all_off && run_enable |-> next_s.ph == st_charge)
		else $error("all-off did not lead to charge");
	brake_exit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		seq_brake_done |=> s.ph == (cfg.startup_mode_select ? st_drive : st_hold))
		else $error("brake end did not pick start mode");
	mode_pick_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(s.ph == st_hold) |-> $past(cfg.startup_mode_select) == 1'b0)
		else $error("hold entered in ramp mode");
	hold_drive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		s.ph == st_hold |=> drive.dc_hold && drive.hold_level <= hold_target)
		else $error("hold output wrong");
	run_closed_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		s.ph == st_run |=> drive.closed_loop && !drive.open_loop)
		else $error("run not closed loop");
	ramp_floor_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		drive.open_loop |-> drive.speed_pct >= 8'h19 && drive.speed_pct <= 8'h64)
		else $error("ramp speed out of range");
	estimate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		s.ph == st_drive && !s.estimate |-> ##0 !drive.closed_loop)
		else $error("estimate too early");
	uc_exit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		s.ph == st_user_brake && above_st && run_enable |=> s.ph == st_all_off)
		else $error("user brake did not end");
	uc_skip_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		s.ph == st_user_brake && !uc_visible |=> !drive.low_side_on)
		else $error("short user brake not skipped");
	wm_limit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		s.ph == st_wm_brake && at_limit && $stable(s.ph) |=> $stable(ramp_level))
		else $error("windmill duty rose past limit");
endmodule : motor_startup_sequencer

// file: motor_bridge_model.sv
// far side: inverter bridge and a windmilling rotor
// assumes the drive_s outputs of the sequencer
`timescale 1ns/100ps
module motor_bridge_model #(
	parameter int SPIN0 = 120
) (
	input  wire logic                core_clk,
	input  wire logic                spin_up,
	input  wire startup_pkg::drive_s drive,
	output logic [1:0]               current_level
);
	import startup_pkg::*;
	int spin;
	// shorted windings drain rotor energy
	always @(posedge core_clk) begin
		if (spin_up) begin
			spin <= SPIN0;
		end else if (drive.low_side_on && drive.low_duty != 8'h00 && spin > 0) begin
			spin <= spin - 1;
		end
	end
	// current follows duty until the rotor stops
	assign current_level = (spin > 0 && drive.low_side_on) ? drive.low_duty[7:6] : 2'h0;
endmodule : motor_bridge_model

// file: motor_startup_sequencer_tb_top.sv
// testbench for the startup sequencer
// assumes the bridge model drives the current pins
`timescale 1ns/100ps
module motor_startup_sequencer_tb_top;
	import startup_pkg::*;
	logic       core_clk = 1'b0;
	logic       resetn = 1'b0;
	logic       run_enable = 1'b0;
	config_s    cfg = '{1'b0, 4'h4, 6'h03, 4'hA, 5'h10, 5'h08, 2'h3, 2'h1};
	logic       in_range = 1'b0;
	logic       above = 1'b0;
	logic       spin_up = 1'b1;
	logic [1:0] current_level;
	drive_s     drive;
	phase_e     phase;
	phase_e     prev = st_off;
	logic       pos_est;
	logic       ub_drive;
	logic       order_ok;
	logic [7:0] visited;
	logic [7:0] wm_duty;
	logic [7:0] hold_lvl;
	logic [7:0] first_speed;
	int         bad_count = 0;
	int         samples_checked = 0;
	always #4 core_clk = ~core_clk;
	motor_startup_sequencer #(.RAMP_CYCLES(64), .BRAKE_SKIP_CYCLES(16), .CHARGE_CYCLES(16),
		.HOLD_UNIT_CYCLES(4), .STEP_CYCLES(2)) i_motor_startup_sequencer (.core_clk(core_clk),
		.resetn(resetn), .run_enable(run_enable), .cfg(cfg), .vsp_in_brake_range(in_range),
		.vsp_above_start(above), .current_level(current_level), .drive(drive), .phase(phase),
		.position_estimate(pos_est));
	motor_bridge_model #(.SPIN0(600)) i_motor_bridge_model (.core_clk(core_clk), .spin_up(spin_up), .drive(drive),
		.current_level(current_level));
	// phase history and values seen per phase
	always @(posedge core_clk) begin
		visited[phase] <= 1'b1;
		prev <= phase;
		if (run_enable && phase < prev) begin
			order_ok <= 1'b0;
		end
		if (phase == st_user_brake && drive.low_side_on) begin
			ub_drive <= 1'b1;
		end
		if (phase == st_wm_brake && drive.low_side_on) begin
			wm_duty <= drive.low_duty;
		end
		if (phase == st_hold && drive.dc_hold) begin
			hold_lvl <= drive.hold_level;
		end
		if (phase == st_drive && prev != st_drive) begin
			first_speed <= drive.speed_pct;
		end
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wait_phase(input phase_e p);
		for (int n = 0; n < 4000 && phase !== p; n++) begin
			@(negedge core_clk);
		end
		if (phase !== p) begin
			chk("phase wait", p, phase);
			stop_test();
		end
		@(negedge core_clk);
	endtask : wait_phase
	task automatic start(input logic mode, input int brake_len);
		run_enable = 1'b0;
		above = 1'b0;
		spin_up = 1'b1;
		repeat (3) @(negedge core_clk);
		cfg.startup_mode_select = mode;
		visited = 8'h00;
		ub_drive = 1'b0;
		order_ok = 1'b1;
		wm_duty = 8'h00;
		hold_lvl = 8'h00;
		spin_up = 1'b0;
		in_range = 1'b1;
		run_enable = 1'b1;
		repeat (brake_len) @(negedge core_clk);
		in_range = 1'b0;
		chk("held in user brake", st_user_brake, phase);
		chk("user brake drive", brake_len > 20, ub_drive);
		above = 1'b1;
	endtask : start
	initial begin
		repeat (6) @(negedge core_clk);
		resetn = 1'b1;
		repeat (4) @(negedge core_clk);
		start(1'b0, 5);
		wait_phase(st_run);
		chk("phase order", 8'h01, order_ok);
		chk("dc path", 8'hBF, visited);
		chk("brake end duty", 8'hFF, wm_duty);
		chk("stopped current", 8'h00, current_level);
		chk("hold level", 8'hAF, hold_lvl);
		chk("closed loop", 8'h01, drive.closed_loop);
		chk("hold released", 8'h00, drive.dc_hold);
		$display("test dc alignment done");
		start(1'b1, 40);
		wait_phase(st_drive);
		chk("open loop", 8'h01, drive.open_loop);
		chk("no estimate yet", 8'h00, pos_est);
		wait_phase(st_run);
		chk("phase order", 8'h01, order_ok);
		chk("ramp path", 8'hDF, visited);
		chk("first speed", 8'h19, first_speed);
		chk("run speed", 8'h64, drive.speed_pct);
		chk("estimate", 8'h01, pos_est);
		chk("closed loop", 8'h01, drive.closed_loop);
		$display("test ramp-up done");
		start(1'b1, 5);
		wait_phase(st_charge);
		run_enable = 1'b0;
		repeat (2) @(negedge core_clk);
		chk("abort phase", st_off, phase);
		chk("abort drive", 8'h00, drive.low_side_on);
		$display("test abort done");
		stop_test();
	end
endmodule : motor_startup_sequencer_tb_top
